// ---- include/adc_trim_pkg.sv ----
/*
 * Constants, types and helpers for the converter trim register bank.
 * Assumes a 32-bit Avalon-MM slave port with byte addressing and one 200 MHz clock.
 */
// Summary of operation
// [RL1] Each sample time trim is an 8-bit read/write value that moves the sampling moment of its core.
// [RL2] The applied sample time trim of a core is chosen from the channel mode and the background phase.
// [RL3] Index 0x087 holds the sample time trim used while core C stands in for core A in dual mode.
// [RL4] Index 0x088 holds the sample time trim used while core C stands in for core B in dual mode.
// [RL5] Index 0x089 holds the sample time trim applied to core B in dual mode.
// [RL6] After reset every trim shows its factory value, which software may read and overwrite.
// [RL7] Each offset trim has a 12-bit unsigned value in its low bits and a 4-bit read/write field above, reset to zero.
// [RL8] The offset at 0x08A-0x08B is applied, unsigned, only while core zero samples the first analog input.
// [RL9] The offset at 0x08C-0x08D is applied only while core zero samples the second analog input.
// [RL10] The offset at 0x08E-0x08F is applied only while core one samples the first analog input.
// [RL11] Software must not write an offset trim while a foreground calibration runs.
// [RL12] Software must not write an offset trim while both background enables are set.
// [RL13] With foreground offset calibration on and background offset off, read offsets only once foreground is complete.
// [RL14] With both background enables on, read offsets only while calibration is halted.
// [RL15] Index 0x090-0x091 holds the offset applied while core one samples the second analog input, same layout.
// [RL16] Software writes zeros to the upper four bits of every offset trim.
package adc_trim_pkg;

    localparam int ADDR_W       = 12;
    localparam int DATA_W       = 32;
    localparam int IDX_W        = 10;
    localparam int IDX_LSB      = 2;
    localparam int TIME_W       = 8;
    localparam int OFFSET_W     = 12;
    localparam int OFFSET_REG_W = 16;
    localparam int RSVD_W       = 4;
    localparam int NUM_TIME     = 3;
    localparam int NUM_OFFSET   = 4;

    localparam logic [IDX_W-1:0] IDX_CORE_C_FOR_A = 10'h087;
    localparam logic [IDX_W-1:0] IDX_CORE_C_FOR_B = 10'h088;
    localparam logic [IDX_W-1:0] IDX_CORE_B_DUAL  = 10'h089;
    localparam logic [IDX_W-1:0] IDX_C0_INPUT_A   = 10'h08a;
    localparam logic [IDX_W-1:0] IDX_C0_INPUT_B   = 10'h08c;
    localparam logic [IDX_W-1:0] IDX_C1_INPUT_A   = 10'h08e;
    localparam logic [IDX_W-1:0] IDX_C1_INPUT_B   = 10'h090;
    localparam logic [IDX_W-1:0] IDX_CAL_STATUS   = 10'h0a0;
    localparam logic [IDX_W-1:0] IDX_ACCESS_FLAGS = 10'h0a1;

    localparam logic [RSVD_W-1:0] RSVD_RESET = 4'h0;

    // Slot numbers inside the trim arrays
    localparam logic [1:0] SLOT_C_FOR_A = 2'h0;
    localparam logic [1:0] SLOT_C_FOR_B = 2'h1;
    localparam logic [1:0] SLOT_B_DUAL  = 2'h2;
    localparam logic [1:0] SLOT_C0_INA  = 2'h0;
    localparam logic [1:0] SLOT_C0_INB  = 2'h1;
    localparam logic [1:0] SLOT_C1_INA  = 2'h2;
    localparam logic [1:0] SLOT_C1_INB  = 2'h3;

    // Calibration status bits
    localparam int ST_FG_BUSY   = 0;
    localparam int ST_FOREGROUND_COMPLETE_FLAG   = 1;
    localparam int ST_HALTED    = 2;
    localparam int ST_BG_EN     = 3;
    localparam int ST_BG_OS_EN  = 4;
    localparam int ST_FG_OS_EN  = 5;
    localparam int ST_WR_LOCKED = 6;
    localparam int ST_RD_UNSAFE = 7;
    localparam int ST_W         = 8;

    // Sticky access flags, write one to clear
    localparam int FL_WR_REFUSED = 0;
    localparam int FL_RD_UNSAFE  = 1;
    localparam int FL_W          = 2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_type;

    typedef logic [TIME_W-1:0]       time_trim_type;
    typedef logic [OFFSET_REG_W-1:0] offset_reg_type;

    function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
        return addr[IDX_LSB +: IDX_W];
    endfunction

    // Merge of byte lanes 0 and 1 into a 16-bit word
    function automatic logic [OFFSET_REG_W-1:0] laneMerge(input logic [OFFSET_REG_W-1:0] old,
                                                         input logic [DATA_W-1:0]       wdata,
                                                         input logic [3:0]              be);
        logic [OFFSET_REG_W-1:0] res;
        res = old;
        if (be[0]) res[7:0] = wdata[7:0];
        if (be[1]) res[15:8] = wdata[15:8];
        return res;
    endfunction

endpackage

// ---- include/trim_bank_if.sv ----
/*
 * Carrier between the register bank and the trim steering logic.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface trim_bank_if;
    import adc_trim_pkg::*;

    time_trim_type              timeTrim   [NUM_TIME];
    offset_reg_type             offsetTrim [NUM_OFFSET];
    logic                       dualMode;
    logic                       bgPhaseForB;
    logic                       core0SecondInput;
    logic                       core1SecondInput;
    logic [TIME_W-1:0]          coreCTime;
    logic [TIME_W-1:0]          coreBTime;
    logic                       timeValid;
    logic [OFFSET_W-1:0]        core0Offset;
    logic [OFFSET_W-1:0]        core1Offset;

    modport bank  (output timeTrim, offsetTrim, dualMode, bgPhaseForB, core0SecondInput, core1SecondInput,
                   input coreCTime, coreBTime, timeValid, core0Offset, core1Offset);
    modport steer (input timeTrim, offsetTrim, dualMode, bgPhaseForB, core0SecondInput, core1SecondInput,
                   output coreCTime, coreBTime, timeValid, core0Offset, core1Offset);
endinterface
`default_nettype wire

// ---- core/trim_steer.sv ----
/*
 * Chooses the trim that each converter core applies and registers it.
 * Assumes mode inputs are already in this clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module trim_steer
    import adc_trim_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    trim_bank_if.steer tb
);

    // [RL2] Mode and phase selection
    always_ff @(posedge clk) begin
        if (rst) begin
            tb.coreCTime <= '0;
            tb.coreBTime <= '0;
            tb.timeValid <= 1'b0;
        end else if (tb.dualMode) begin
            // [RL3] [RL4] Core C stands in
            tb.coreCTime <= tb.bgPhaseForB ? tb.timeTrim[SLOT_C_FOR_B] : tb.timeTrim[SLOT_C_FOR_A];
            // [RL5] Core B dual trim
            tb.coreBTime <= tb.timeTrim[SLOT_B_DUAL];
            tb.timeValid <= 1'b1;
        end else begin
            // Single-channel trims live outside this bank
            tb.coreCTime <= '0;
            tb.coreBTime <= '0;
            tb.timeValid <= 1'b0;
        end
    end

    // [RL8] [RL9] Core zero input pick
    always_ff @(posedge clk) begin
        if (rst) begin
            tb.core0Offset <= '0;
        end else begin
            tb.core0Offset <= tb.core0SecondInput ? tb.offsetTrim[SLOT_C0_INB][OFFSET_W-1:0]
                                                  : tb.offsetTrim[SLOT_C0_INA][OFFSET_W-1:0];
        end
    end

    // [RL10] [RL15] Core one input pick
    always_ff @(posedge clk) begin
        if (rst) begin
            tb.core1Offset <= '0;
        end else begin
            tb.core1Offset <= tb.core1SecondInput ? tb.offsetTrim[SLOT_C1_INB][OFFSET_W-1:0]
                                                  : tb.offsetTrim[SLOT_C1_INA][OFFSET_W-1:0];
        end
    end

endmodule
`default_nettype wire

// ---- core/adc_core_timing_offset_trim_regs.sv ----
/*
 * Register bank of sample time and offset trims for the converter cores,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes mode, calibration and factory trim inputs come from logic on ref_clk,
 * and that the factory values are stable while sys_rst is high.
 */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_core_timing_offset_trim_regs
    import adc_trim_pkg::*;
(
    input  wire logic                                 ref_clk,
    input  wire logic                                 sys_rst,
    input  wire logic [ADDR_W-1:0]                    avs_address,
    input  wire logic                                 avs_read,
    input  wire logic                                 avs_write,
    input  wire logic [DATA_W-1:0]                    avs_writedata,
    input  wire logic [3:0]                           avs_byteenable,
    output logic      [DATA_W-1:0]                    avs_readdata,
    output logic                                      avs_waitrequest,
    input  wire logic [NUM_TIME-1:0][TIME_W-1:0]      factoryTimeTrim,
    input  wire logic [NUM_OFFSET-1:0][OFFSET_W-1:0]  factoryOffsetTrim,
    input  wire logic                                 dualChannelMode,
    input  wire logic                                 bgPhaseForB,
    input  wire logic                                 core0SecondInput,
    input  wire logic                                 core1SecondInput,
    input  wire logic                                 backgroundCalibrationEnable,
    input  wire logic                                 backgroundOffsetCalibrationEnable,
    input  wire logic                                 foregroundOffsetCalibrationEnable,
    input  wire logic                                 foregroundCalibrationBusy,
    input  wire logic                                 foregroundCompleteFlag,
    input  wire logic                                 calibrationHaltedFlag,
    output logic      [TIME_W-1:0]                    coreCSampleTimeTrim,
    output logic      [TIME_W-1:0]                    coreBSampleTimeTrim,
    output logic                                      sampleTimeTrimValid,
    output logic      [OFFSET_W-1:0]                  core0OffsetTrim,
    output logic      [OFFSET_W-1:0]                  core1OffsetTrim
);

    trim_bank_if tb ();

    bus_state_type      busState_q;
    bus_state_type      busState_d;
    time_trim_type      timeTrim_q   [NUM_TIME];
    offset_reg_type     offsetTrim_q [NUM_OFFSET];
    logic [FL_W-1:0]    accessFlags_q;
    logic [DATA_W-1:0]  readData_q;
    logic               waitReq_q;

    logic [IDX_W-1:0]   index;
    logic               request;
    logic               wrStrobe;
    logic               rdStrobe;
    logic               timeHit;
    logic [1:0]         timeSlot;
    logic               offsetHit;
    logic [1:0]         offsetSlot;
    logic               writeLocked;
    logic               readUnsafe;
    logic [ST_W-1:0]    calStatus;
    logic [DATA_W-1:0]  readMux;

    assign index    = regIndex(avs_address);
    assign request  = avs_read | avs_write;
    assign wrStrobe = (busState_q == BUS_IDLE) && avs_write;
    assign rdStrobe = (busState_q == BUS_IDLE) && avs_read;

    // Address decode to array slots
    always_comb begin
        timeHit    = 1'b0;
        timeSlot   = SLOT_C_FOR_A;
        offsetHit  = 1'b0;
        offsetSlot = SLOT_C0_INA;
        unique case (index)
            // [RL3] Core C for core A
            IDX_CORE_C_FOR_A: begin
                timeHit  = 1'b1;
                timeSlot = SLOT_C_FOR_A;
            end
            // [RL4] Core C for core B
            IDX_CORE_C_FOR_B: begin
                timeHit  = 1'b1;
                timeSlot = SLOT_C_FOR_B;
            end
            // [RL5] Core B dual
            IDX_CORE_B_DUAL: begin
                timeHit  = 1'b1;
                timeSlot = SLOT_B_DUAL;
            end
            // [RL8] Core zero first input
            IDX_C0_INPUT_A: begin
                offsetHit  = 1'b1;
                offsetSlot = SLOT_C0_INA;
            end
            // [RL9] Core zero second input
            IDX_C0_INPUT_B: begin
                offsetHit  = 1'b1;
                offsetSlot = SLOT_C0_INB;
            end
            // [RL10] Core one first input
            IDX_C1_INPUT_A: begin
                offsetHit  = 1'b1;
                offsetSlot = SLOT_C1_INA;
            end
            // [RL15] Core one second input
            IDX_C1_INPUT_B: begin
                offsetHit  = 1'b1;
                offsetSlot = SLOT_C1_INB;
            end
            default: begin
                timeHit   = 1'b0;
                offsetHit = 1'b0;
            end
        endcase
    end

    // [RL11] [RL12] Offset write lock
    // Guarding here keeps a stray write from corrupting a running calibration.
    assign writeLocked = foregroundCalibrationBusy |
                         (backgroundCalibrationEnable & backgroundOffsetCalibrationEnable);

    // [RL13] [RL14] Unsafe read window
    assign readUnsafe = (foregroundOffsetCalibrationEnable & ~backgroundOffsetCalibrationEnable &
                         ~foregroundCompleteFlag) |
                        (backgroundCalibrationEnable & backgroundOffsetCalibrationEnable &
                         ~calibrationHaltedFlag);

    always_comb begin
        calStatus               = '0;
        calStatus[ST_FG_BUSY]   = foregroundCalibrationBusy;
        calStatus[ST_FOREGROUND_COMPLETE_FLAG]   = foregroundCompleteFlag;
        calStatus[ST_HALTED]    = calibrationHaltedFlag;
        calStatus[ST_BG_EN]     = backgroundCalibrationEnable;
        calStatus[ST_BG_OS_EN]  = backgroundOffsetCalibrationEnable;
        calStatus[ST_FG_OS_EN]  = foregroundOffsetCalibrationEnable;
        calStatus[ST_WR_LOCKED] = writeLocked;
        calStatus[ST_RD_UNSAFE] = readUnsafe;
    end

    // Bus handshake, one answer cycle per request
    always_comb begin
        busState_d = busState_q;
        unique case (busState_q)
            BUS_IDLE: begin
                if (request) begin
                    busState_d = BUS_ACK;
                end
            end
            BUS_ACK: begin
                busState_d = BUS_IDLE;
            end
            default: begin
                busState_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busState_q <= BUS_IDLE;
        end else begin
            busState_q <= busState_d;
        end
    end

    // Waitrequest drops for exactly the answer cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            waitReq_q <= 1'b1;
        end else begin
            waitReq_q <= ~(busState_d == BUS_ACK);
        end
    end

    // [RL1] [RL6] Sample time trims, factory value on reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                timeTrim_q[i] <= factoryTimeTrim[i];
            end
        end else if (wrStrobe && timeHit && avs_byteenable[0]) begin
            timeTrim_q[timeSlot] <= avs_writedata[TIME_W-1:0];
        end
    end

    // [RL6] [RL7] Offset trims, factory value with zero upper field
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_OFFSET; i++) begin
                offsetTrim_q[i] <= {RSVD_RESET, factoryOffsetTrim[i]};
            end
        end else if (wrStrobe && offsetHit && !writeLocked) begin
            // [RL7] Upper field is stored as written
            offsetTrim_q[offsetSlot] <= laneMerge(offsetTrim_q[offsetSlot], avs_writedata, avs_byteenable);
        end
    end

    // Sticky access flags; a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accessFlags_q <= '0;
        end else begin
            if (wrStrobe && index == IDX_ACCESS_FLAGS && avs_byteenable[0]) begin
                accessFlags_q <= accessFlags_q & ~avs_writedata[FL_W-1:0];
            end
            // [RL11] [RL12] Refused write recorded
            if (wrStrobe && offsetHit && writeLocked) begin
                accessFlags_q[FL_WR_REFUSED] <= 1'b1;
            end
            // [RL13] [RL14] Early read recorded
            if (rdStrobe && offsetHit && readUnsafe) begin
                accessFlags_q[FL_RD_UNSAFE] <= 1'b1;
            end
        end
    end

    // Read data; unmapped and unused bits read zero, the reserved offset bits read as stored
    always_comb begin
        readMux = '0;
        if (timeHit) begin
            readMux[TIME_W-1:0] = timeTrim_q[timeSlot];
        end else if (offsetHit) begin
            readMux[OFFSET_REG_W-1:0] = offsetTrim_q[offsetSlot];
        end else if (index == IDX_CAL_STATUS) begin
            readMux[ST_W-1:0] = calStatus;
        end else if (index == IDX_ACCESS_FLAGS) begin
            readMux[FL_W-1:0] = accessFlags_q;
        end
    end

    // Data held until the next read answer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readData_q <= '0;
        end else if (rdStrobe) begin
            readData_q <= readMux;
        end
    end

    assign avs_readdata    = readData_q;
    assign avs_waitrequest = waitReq_q;

    // [RL2] Bank side of the steering carrier
    assign tb.timeTrim         = timeTrim_q;
    assign tb.offsetTrim       = offsetTrim_q;
    assign tb.dualMode         = dualChannelMode;
    assign tb.bgPhaseForB      = bgPhaseForB;
    assign tb.core0SecondInput = core0SecondInput;
    assign tb.core1SecondInput = core1SecondInput;

    trim_steer steer (
        .clk (ref_clk),
        .rst (sys_rst),
        .tb  (tb.steer)
    );

    // Steering outputs are flops inside the steering module
    assign coreCSampleTimeTrim = tb.coreCTime;
    assign coreBSampleTimeTrim = tb.coreBTime;
    assign sampleTimeTrimValid = tb.timeValid;
    assign core0OffsetTrim     = tb.core0Offset;
    assign core1OffsetTrim     = tb.core1Offset;

endmodule
`default_nettype wire

// ---- tb/adc_trim_properties.sv ----
/* Port checker for the trim register bank.
   Bound to the bank top; sees its ports only, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module adc_trim_properties
    import adc_trim_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire logic [ADDR_W-1:0]   avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [DATA_W-1:0]   avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [DATA_W-1:0]   avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic                dualChannelMode,
    input wire logic                bgPhaseForB,
    input wire logic                core0SecondInput,
    input wire logic                core1SecondInput,
    input wire logic                backgroundCalibrationEnable,
    input wire logic                backgroundOffsetCalibrationEnable,
    input wire logic                foregroundCalibrationBusy,
    input wire logic [TIME_W-1:0]   coreCSampleTimeTrim,
    input wire logic [TIME_W-1:0]   coreBSampleTimeTrim,
    input wire logic                sampleTimeTrimValid,
    input wire logic [OFFSET_W-1:0] core0OffsetTrim,
    input wire logic [OFFSET_W-1:0] core1OffsetTrim
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic locked = foregroundCalibrationBusy | (backgroundCalibrationEnable & backgroundOffsetCalibrationEnable);
    wire logic wrDone = !avs_waitrequest && avs_write;

    answer_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    answer_next_a: assert property ($rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    no_spurious_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    unmapped_zero_a: assert property (!avs_waitrequest && avs_read && avs_address == 12'h3fc |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    mode_off_a: assert property (!dualChannelMode |=> !sampleTimeTrimValid && coreCSampleTimeTrim == 8'h0)
        else $error("time trim driven outside dual mode");
    core_c_write_a: assert property (wrDone && avs_address == 12'h21c && avs_byteenable[0] && dualChannelMode
        && !bgPhaseForB |=> coreCSampleTimeTrim == $past(avs_writedata[7:0]))
        else $error("core C trim for A not applied");
    core_b_write_a: assert property (wrDone && avs_address == 12'h224 && avs_byteenable[0] && dualChannelMode
        |=> coreBSampleTimeTrim == $past(avs_writedata[7:0]))
        else $error("core B trim not applied");
    offset_zero_a: assert property (wrDone && avs_address == 12'h228 && avs_byteenable[1:0] == 2'b11
        && !$past(locked) && !core0SecondInput |=> core0OffsetTrim == $past(avs_writedata[11:0]))
        else $error("core zero first input offset not applied");
    offset_last_a: assert property (wrDone && avs_address == 12'h240 && avs_byteenable[1:0] == 2'b11
        && !$past(locked) && core1SecondInput |=> core1OffsetTrim == $past(avs_writedata[11:0]))
        else $error("core one second input offset not applied");
    locked_drop_a: assert property (wrDone && avs_address == 12'h228 && $past(locked) && !core0SecondInput
        && !$past(core0SecondInput) |=> $stable(core0OffsetTrim))
        else $error("locked offset write took effect");

    cover property (wrDone && $past(locked));
    cover property (dualChannelMode && bgPhaseForB && sampleTimeTrimValid);
    cover property (!avs_waitrequest && avs_read);
endmodule
bind adc_core_timing_offset_trim_regs adc_trim_properties adc_trim_properties_inst (.*);
`default_nettype wire

// ---- tb/adc_core_timing_offset_trim_regs_tb.sv ----
/* Self-checking bench for the trim register bank.
   Drives the Avalon port and all mode inputs; expects the checker bound. */
`timescale 1ns/1ps
`default_nettype none
module adc_core_timing_offset_trim_regs_tb
    import adc_trim_pkg::*;
;
    logic                                ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0]                   avs_address;
    logic [DATA_W-1:0]                   avs_writedata, avs_readdata;
    logic [3:0]                          avs_byteenable;
    logic [NUM_TIME-1:0][TIME_W-1:0]     factoryTimeTrim;
    logic [NUM_OFFSET-1:0][OFFSET_W-1:0] factoryOffsetTrim;
    logic                                dualChannelMode, bgPhaseForB, core0SecondInput, core1SecondInput;
    logic                                backgroundCalibrationEnable, backgroundOffsetCalibrationEnable;
    logic                                foregroundOffsetCalibrationEnable, foregroundCalibrationBusy;
    logic                                foregroundCompleteFlag, calibrationHaltedFlag, sampleTimeTrimValid;
    logic [TIME_W-1:0]                   coreCSampleTimeTrim, coreBSampleTimeTrim;
    logic [OFFSET_W-1:0]                 core0OffsetTrim, core1OffsetTrim;
    logic [31:0]                         seed = 32'h4a2219bd;
    logic [31:0]                         rd, d;
    logic [3:0]                          be;
    logic [15:0]                         expReg [7];
    logic [11:0]                         addrTab [7] = '{12'h21c, 12'h220, 12'h224, 12'h228, 12'h230, 12'h238, 12'h240};
    logic [4:0]                          calCase [4] = '{5'b00100, 5'b00110, 5'b11000, 5'b11001};
    int                                  k, n_mismatch = 0, compares = 0, cycles = 0;

    adc_core_timing_offset_trim_regs adc_core_timing_offset_trim_regs_inst (.*);

    function automatic logic [31:0] rand32();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Time trims only take lane 0
    function automatic logic [15:0] mergeExp(int idx, logic [15:0] old, logic [31:0] wd, logic [3:0] en);
        if (en[0]) old[7:0] = wd[7:0];
        if (en[1] && idx > 2) old[15:8] = wd[15:8];
        return old;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] en,
                        output logic [31:0] r);
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= en;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic readCheck(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, 4'hf, r);
        check(r, exp);
    endtask

    task wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Far above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end

    initial begin
        {avs_read, avs_write, dualChannelMode, bgPhaseForB, core0SecondInput, core1SecondInput} = '0;
        {backgroundCalibrationEnable, backgroundOffsetCalibrationEnable, foregroundOffsetCalibrationEnable} = '0;
        {foregroundCalibrationBusy, foregroundCompleteFlag, calibrationHaltedFlag} = '0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = '0;
        factoryTimeTrim = 24'(rand32());
        factoryOffsetTrim = 48'({rand32(), rand32()});
        sys_rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) expReg[i] = i < 3 ? 16'(factoryTimeTrim[i]) : 16'(factoryOffsetTrim[i-3]);
        for (int i = 0; i < 7; i++) readCheck(addrTab[i], 32'(expReg[i]));
        dualChannelMode <= 1'b1;
        core1SecondInput <= 1'b1;
        for (int i = 0; i < 37; i++) begin
            k = i < 7 ? i : int'(rand32() % 7);
            d = rand32();
            be = i < 20 ? 4'hf : d[19:16];
            if (k > 2) d[15:12] = 4'h0; // Reserved kept zero
            xfer(1'b1, addrTab[k], d, be, rd);
            expReg[k] = mergeExp(k, expReg[k], d, be);
            readCheck(addrTab[k], 32'(expReg[k]));
        end
        for (int m = 0; m < 16; m++) begin
            @(posedge ref_clk);
            {dualChannelMode, bgPhaseForB, core0SecondInput, core1SecondInput} <= 4'(m);
            repeat (2) @(posedge ref_clk);
            check(32'(coreCSampleTimeTrim), m[3] ? 32'(expReg[m[2]][7:0]) : 32'h0);
            check(32'(coreBSampleTimeTrim), m[3] ? 32'(expReg[2][7:0]) : 32'h0);
            check(32'(sampleTimeTrimValid), 32'(m[3]));
            check(32'(core0OffsetTrim), 32'(expReg[m[1] ? 4 : 3][11:0]));
            check(32'(core1OffsetTrim), 32'(expReg[m[0] ? 6 : 5][11:0]));
        end
        for (int j = 0; j < 2; j++) begin
            @(posedge ref_clk);
            foregroundCalibrationBusy <= (j == 0);
            backgroundCalibrationEnable <= (j == 1);
            backgroundOffsetCalibrationEnable <= (j == 1);
            core0SecondInput <= 1'b0;
            xfer(1'b1, 12'h284, 32'h3, 4'h1, rd);
            xfer(1'b1, 12'h228, rand32() & 32'h0fff, 4'h3, rd); // Write while locked
            readCheck(12'h284, 32'h1);
            readCheck(12'h280, j ? 32'hd8 : 32'h41);
            readCheck(12'h228, 32'(expReg[3]));
        end
        for (int j = 0; j < 4; j++) begin
            @(posedge ref_clk);
            {backgroundCalibrationEnable, backgroundOffsetCalibrationEnable, foregroundOffsetCalibrationEnable,
             foregroundCompleteFlag, calibrationHaltedFlag} <= calCase[j];
            foregroundCalibrationBusy <= 1'b0;
            xfer(1'b1, 12'h284, 32'h3, 4'h1, rd);
            readCheck(12'h230, 32'(expReg[4]));
            readCheck(12'h284, j[0] ? 32'h0 : 32'h2);
        end
        xfer(1'b1, 12'h3fc, rand32(), 4'hf, rd);
        readCheck(12'h3fc, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
